// *** hdl/pci_addr_data_port.sv ***
// Purpose: PCI multiplexed address/data and command/byte-enable port, with clock-run
// Assumes: bus pins sampled through two flops; framing handled by a neighbouring block
// Notes: target write data is queued through a 32-word FIFO
`timescale 1ns/1ps
`default_nettype none
`include "pci_port_consts.svh"
module pci_addr_data_port #(
    parameter int AD_W = `PCI_AD_W,
    parameter int DEPTH = `PCI_FIFO_DEPTH,
    parameter int STOP_WAIT = `PCI_STOP_WAIT_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // bus reset and suspend
    input wire logic pci_bus_reset_in_n_i,
    input wire logic pos_i,
    // framing from neighbouring logic
    input wire logic tgt_start_i,
    input wire logic tgt_read_i,
    input wire logic phase_done_i,
    input wire logic last_i,
    // address/data pins
    input wire logic [AD_W-1:0] ad_i,
    output logic [AD_W-1:0] ad_o,
    output logic ad_oe_o,
    // command/byte-enable pins, active low
    input wire logic [3:0] cbe_n_i,
    output logic [3:0] cbe_n_o,
    output logic cbe_oe_o,
    // clock-run pin, active low
    input wire logic clkrun_n_i,
    output logic clkrun_n_o,
    output logic clkrun_oe_o,
    // clock stop control
    input wire logic stop_req_i,
    output logic clk_stop_o,
    // initiator request
    input wire logic mst_req_i,
    input wire logic mst_write_i,
    input wire logic [AD_W-1:0] mst_addr_i,
    input wire logic [3:0] mst_cmd_i,
    input wire logic [3:0] mst_be_n_i,
    input wire logic [AD_W-1:0] mst_wdata_i,
    output logic mst_busy_o,
    output logic [AD_W-1:0] mst_rdata_o,
    output logic mst_rvalid_o,
    // target side
    output logic [AD_W-1:0] tgt_addr_o,
    output logic [3:0] tgt_cmd_o,
    input wire logic [AD_W-1:0] tgt_rdata_i,
    output logic wr_valid_o,
    output logic [AD_W+3:0] wr_data_o,
    input wire logic wr_ready_i,
    output logic tgt_stall_o
);
    // ****************************************************
    // input synchronisers
    // ****************************************************
    logic [AD_W-1:0] ad_m_q, ad_s_q;
    logic [3:0] cbe_m_q, cbe_s_q;
    logic [6:0] ctl_m_q, ctl_s_q;
    logic [6:0] ctl_raw;
    assign ctl_raw = {pci_bus_reset_in_n_i, pos_i, tgt_start_i, tgt_read_i,
                      phase_done_i, last_i, clkrun_n_i};
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ad_m_q <= '0;
            ad_s_q <= '0;
            cbe_m_q <= `PCI_CBE_IDLE;
            cbe_s_q <= `PCI_CBE_IDLE;
            ctl_m_q <= 7'h41;
            ctl_s_q <= 7'h41;
        end else begin
            ad_m_q <= ad_i;
            ad_s_q <= ad_m_q;
            cbe_m_q <= cbe_n_i;
            cbe_s_q <= cbe_m_q;
            ctl_m_q <= ctl_raw;
            ctl_s_q <= ctl_m_q;
        end
    end
    logic bus_rst, pos_s, t_start, t_read, p_done, p_last, clkrun_held;
    assign bus_rst = !ctl_s_q[6] || rst_i;
    assign pos_s = ctl_s_q[5];
    assign t_start = ctl_s_q[4];
    assign t_read = ctl_s_q[3];
    assign p_done = ctl_s_q[2];
    assign p_last = ctl_s_q[1];
    assign clkrun_held = !ctl_s_q[0];

    // ****************************************************
    // byte lane merge
    // ****************************************************
    function automatic logic [AD_W-1:0] lane_merge(input logic [AD_W-1:0] old_w,
            input logic [AD_W-1:0] new_w, input logic [3:0] be_n);
        logic [AD_W-1:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (!be_n[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************************
    // target write FIFO
    // ****************************************************
    fifo_if #(.W(AD_W+4)) wq_in ();
    fifo_if #(.W(AD_W+4)) wq_out ();
    word_fifo #(.W(AD_W+4), .DEPTH(DEPTH)) u_wq (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .in_s(wq_in.snk),
        .out_s(wq_out.src)
    );
    assign wr_valid_o = wq_out.valid;
    assign wr_data_o = wq_out.data;
    assign wq_out.ready = wr_ready_i;

    // ****************************************************
    // bus phase machine
    // ****************************************************
    pci_port_pkg::bus_state_e st_q, st_d;
    logic [AD_W-1:0] ad_q, ad_d, rdata_q, rdata_d, taddr_q, taddr_d;
    logic [3:0] cbe_q, cbe_d, tcmd_q, tcmd_d;
    logic ad_oe_q, ad_oe_d, cbe_oe_q, cbe_oe_d, rv_q, rv_d;
    logic wr_push, t_write_q, t_write_d;
    assign wr_push = (st_q == pci_port_pkg::ST_T_DATA) && t_write_q && p_done;
    assign wq_in.valid = wr_push;
    assign wq_in.data = {cbe_s_q, ad_s_q};
    assign tgt_stall_o = !wq_in.ready;
    always_comb begin
        st_d = st_q;
        ad_d = ad_q;
        cbe_d = cbe_q;
        ad_oe_d = ad_oe_q;
        cbe_oe_d = cbe_oe_q;
        rdata_d = rdata_q;
        rv_d = 1'b0;
        taddr_d = taddr_q;
        tcmd_d = tcmd_q;
        t_write_d = t_write_q;
        case (st_q)
            pci_port_pkg::ST_IDLE: begin
                ad_oe_d = 1'b0;
                cbe_oe_d = 1'b0;
                if (t_start) begin
                    taddr_d = ad_s_q;
                    tcmd_d = cbe_s_q;
                    t_write_d = !t_read;
                    st_d = pci_port_pkg::ST_T_DATA;
                end else if (mst_req_i) begin
                    ad_d = {mst_addr_i[AD_W-1:2], `PCI_ADDR_LOW_ZERO};
                    cbe_d = mst_cmd_i;
                    ad_oe_d = 1'b1;
                    cbe_oe_d = 1'b1;
                    t_write_d = mst_write_i;
                    st_d = pci_port_pkg::ST_M_ADDR;
                end
            end
            pci_port_pkg::ST_M_ADDR: begin
                cbe_d = mst_be_n_i;
                ad_d = mst_wdata_i;
                ad_oe_d = t_write_q;
                st_d = pci_port_pkg::ST_M_DATA;
            end
            pci_port_pkg::ST_M_DATA: begin
                if (p_done) begin
                    if (!t_write_q) begin
                        rdata_d = lane_merge(rdata_q, ad_s_q, cbe_q);
                        rv_d = 1'b1;
                    end
                    ad_d = mst_wdata_i;
                    cbe_d = mst_be_n_i;
                    if (p_last) begin
                        st_d = pci_port_pkg::ST_TURN;
                    end
                end
            end
            pci_port_pkg::ST_T_DATA: begin
                ad_oe_d = !t_write_q;
                ad_d = tgt_rdata_i;
                if (p_done && p_last) begin
                    st_d = pci_port_pkg::ST_TURN;
                end
            end
            pci_port_pkg::ST_TURN: begin
                ad_oe_d = 1'b0;
                cbe_oe_d = 1'b0;
                st_d = pci_port_pkg::ST_IDLE;
            end
            default: begin
                st_d = pci_port_pkg::ST_IDLE;
            end
        endcase
        if (bus_rst || pos_s) begin
            st_d = pci_port_pkg::ST_IDLE;
            ad_oe_d = 1'b0;
            cbe_oe_d = 1'b0;
        end
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= pci_port_pkg::ST_IDLE;
            ad_q <= '0;
            cbe_q <= `PCI_CBE_IDLE;
            ad_oe_q <= 1'b0;
            cbe_oe_q <= 1'b0;
            rdata_q <= '0;
            rv_q <= 1'b0;
            taddr_q <= '0;
            tcmd_q <= '0;
            t_write_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ad_q <= ad_d;
            cbe_q <= cbe_d;
            ad_oe_q <= ad_oe_d;
            cbe_oe_q <= cbe_oe_d;
            rdata_q <= rdata_d;
            rv_q <= rv_d;
            taddr_q <= taddr_d;
            tcmd_q <= tcmd_d;
            t_write_q <= t_write_d;
        end
    end
    assign ad_o = ad_q;
    assign ad_oe_o = ad_oe_q;
    assign cbe_n_o = cbe_q;
    assign cbe_oe_o = cbe_oe_q;
    assign mst_rdata_o = rdata_q;
    assign mst_rvalid_o = rv_q;
    assign mst_busy_o = (st_q != pci_port_pkg::ST_IDLE);
    assign tgt_addr_o = taddr_q;
    assign tgt_cmd_o = tcmd_q;

    // ****************************************************
    // clock-run control
    // ****************************************************
    pci_port_pkg::clk_state_e ck_q, ck_d;
    logic [7:0] ck_cnt_q, ck_cnt_d;
    always_comb begin
        ck_d = ck_q;
        ck_cnt_d = ck_cnt_q;
        case (ck_q)
            pci_port_pkg::CK_RUN: begin
                if (stop_req_i && !clkrun_held) begin
                    ck_d = pci_port_pkg::CK_WARN;
                    ck_cnt_d = 8'(STOP_WAIT);
                end
            end
            pci_port_pkg::CK_WARN: begin
                if (clkrun_held || !stop_req_i) begin
                    ck_d = pci_port_pkg::CK_RUN;
                end else if (ck_cnt_q <= 8'h01) begin
                    ck_d = pci_port_pkg::CK_STOPPED;
                end else begin
                    ck_cnt_d = ck_cnt_q - 8'h01;
                end
            end
            pci_port_pkg::CK_STOPPED: begin
                if (clkrun_held || !stop_req_i) begin
                    ck_d = pci_port_pkg::CK_RUN;
                end
            end
            default: begin
                ck_d = pci_port_pkg::CK_RUN;
            end
        endcase
        if (bus_rst) begin
            ck_d = pci_port_pkg::CK_RUN;
        end
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ck_q <= pci_port_pkg::CK_RUN;
            ck_cnt_q <= '0;
        end else begin
            ck_q <= ck_d;
            ck_cnt_q <= ck_cnt_d;
        end
    end
    // driven high in CK_RUN except during bus reset; released in CK_WARN to warn that the stop is coming
    assign clkrun_n_o = 1'b1;
    assign clkrun_oe_o = (ck_q == pci_port_pkg::CK_RUN) && !bus_rst;
    assign clk_stop_o = (ck_q == pci_port_pkg::CK_STOPPED);

    // ****************************************************
    // checks
    // ****************************************************
    reset_float_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(bus_rst || pos_s) |-> !ad_oe_o && !cbe_oe_o) else $error("pins driven in reset");
    addr_low_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_q == pci_port_pkg::ST_M_ADDR |-> ad_oe_o && ad_o == {$past(mst_addr_i[AD_W-1:2]), 2'h0})
        else $error("bad address phase");
    cbe_target_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_q == pci_port_pkg::ST_T_DATA |-> !cbe_oe_o) else $error("cbe driven as target");
    addr_then_data_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_q == pci_port_pkg::ST_M_ADDR && !bus_rst && !pos_s |=> st_q == pci_port_pkg::ST_M_DATA)
        else $error("no data phase");
    tgt_write_in_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_q == pci_port_pkg::ST_T_DATA && t_write_q |-> !ad_oe_o) else $error("ad driven on write");
    cbe_cmd_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        st_q == pci_port_pkg::ST_M_ADDR |-> cbe_n_o == $past(mst_cmd_i)) else $error("bad command");
    no_stop_held_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        clkrun_held && ck_q != pci_port_pkg::CK_RUN |=> ck_q == pci_port_pkg::CK_RUN)
        else $error("clock stopped while held");
    warn_first_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(clk_stop_o) |-> $past(ck_q) == pci_port_pkg::CK_WARN) else $error("stop without warning");
endmodule // pci_addr_data_port
`default_nettype wire

// *** hdl/pci_port_consts.svh ***
// Purpose: constants for the PCI address/data port
// Assumes: 125 MHz ref_clk_i, single clock domain
// Notes: timing counts assume the 8 ns clock
`ifndef PCI_PORT_CONSTS_SVH
`define PCI_PORT_CONSTS_SVH
`define PCI_AD_W 32
`define PCI_CBE_W 4
`define PCI_FIFO_DEPTH 32
`define PCI_ADDR_LOW_ZERO 2'h0
`define PCI_CBE_IDLE 4'hF
`define PCI_STOP_WAIT_NS 64
`define PCI_STOP_WAIT_CYC ((`PCI_STOP_WAIT_NS + 7) / 8)
`endif

// *** hdl/pci_port_pkg.sv ***
// Purpose: types for the PCI address/data port
// Assumes: nothing
// Notes: none
package pci_port_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_M_ADDR = 3'h1,
        ST_M_DATA = 3'h2,
        ST_T_DATA = 3'h3,
        ST_TURN = 3'h4
    } bus_state_e;
    typedef enum logic [1:0] {
        CK_RUN = 2'h0,
        CK_WARN = 2'h1,
        CK_STOPPED = 2'h2
    } clk_state_e;
endpackage

// *** hdl/fifo_if.sv ***
// Purpose: valid/ready word stream between modules
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface fifo_if #(parameter int W = 36) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** hdl/word_fifo.sv ***
// Purpose: synchronous FIFO, valid/ready on both sides
// Assumes: one clock
// Notes: full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int W = 36,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // streams
    fifo_if.snk in_s,
    fifo_if.src out_s
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop;
    logic full, empty;
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty = (wr_q == rd_q);
    assign in_s.ready = !full;
    assign out_s.valid = !empty;
    assign out_s.data = mem_q[rd_q[AW-1:0]];
    assign push = in_s.valid && !full;
    assign pop = out_s.ready && !empty;
    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_s.data;
        end
    end
    fifo_count_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_q - rd_q) <= DEPTH[AW:0]) else $error("fifo overfilled");
endmodule // word_fifo
`default_nettype wire

// *** tb/pci_far_agent.sv ***
// Purpose: far-side bus agent resolving the AD, command and clock-run wires
// Assumes: one clock; tasks are called just after a rising edge
// Notes: an undriven AD or command bus shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module pci_far_agent (
    // clock
    input wire logic ref_clk_i,
    // device side of the pins
    input wire logic [31:0] dev_ad_i,
    input wire logic dev_ad_oe_i,
    input wire logic [3:0] dev_cbe_n_i,
    input wire logic dev_cbe_oe_i,
    input wire logic dev_clkrun_n_i,
    input wire logic dev_clkrun_oe_i,
    // resolved wires
    output logic [31:0] wire_ad_o,
    output logic [3:0] wire_cbe_n_o,
    output logic wire_clkrun_n_o
);
    logic [31:0] drv_ad = 32'h0;
    logic [3:0] drv_cbe = 4'hF;
    logic drv_en = 1'b0;
    logic hold = 1'b0;
    logic [31:0] last_ad_q = 32'h0;
    logic [3:0] last_cbe_q = 4'h0;
    always_ff @(posedge ref_clk_i) begin
        last_ad_q <= wire_ad_o;
        last_cbe_q <= wire_cbe_n_o;
    end
    // clock-run has a pull-up, low means asserted
    always_comb begin
        wire_ad_o = dev_ad_oe_i ? dev_ad_i : (drv_en ? drv_ad : ~last_ad_q);
        wire_cbe_n_o = dev_cbe_oe_i ? dev_cbe_n_i : (drv_en ? drv_cbe : ~last_cbe_q);
        wire_clkrun_n_o = !((dev_clkrun_oe_i && !dev_clkrun_n_i) || hold);
    end
    // address or data word with command or active-low byte enables
    task automatic set_bus(input logic [31:0] a, input logic [3:0] c);
        drv_ad = a;
        drv_cbe = c;
        drv_en = 1'b1;
    endtask
    task automatic release_bus();
        drv_en = 1'b0;
    endtask
    // keep the clock running or ask for a restart
    task automatic hold_clock(input logic h);
        hold = h;
    endtask
endmodule // pci_far_agent
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: self-checking bench of the address/data port
// Assumes: 125 MHz clock, inputs driven 1 ns after the rising edge
// Notes: fixed seed; short clock-stop wait
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int DEPTH = 32;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic pci_bus_reset_in_n_i, pos_i, tgt_start_i, tgt_read_i, phase_done_i, last_i, ad_oe_o, cbe_oe_o;
    logic clkrun_n_i, clkrun_n_o, clkrun_oe_o, stop_req_i, clk_stop_o, mst_req_i, mst_write_i, mst_busy_o;
    logic mst_rvalid_o, wr_valid_o, wr_ready_i, tgt_stall_o;
    logic [31:0] ad_i, ad_o, mst_addr_i, mst_wdata_i, mst_rdata_o, tgt_addr_o, tgt_rdata_i;
    logic [3:0] cbe_n_i, cbe_n_o, mst_cmd_i, mst_be_n_i, tgt_cmd_o;
    logic [35:0] wr_data_o;
    logic [35:0] exp_q[$];
    int n_errors = 0;
    int num_checks = 0;
    logic [31:0] rd_exp = 32'h0;
    always #4 ref_clk_i = ~ref_clk_i;
    pci_addr_data_port #(.STOP_WAIT(2)) dut (.ref_clk_i, .rst_i, .pci_bus_reset_in_n_i, .pos_i, .tgt_start_i,
        .tgt_read_i, .phase_done_i, .last_i, .ad_i, .ad_o, .ad_oe_o, .cbe_n_i, .cbe_n_o, .cbe_oe_o, .clkrun_n_i,
        .clkrun_n_o, .clkrun_oe_o, .stop_req_i, .clk_stop_o, .mst_req_i, .mst_write_i, .mst_addr_i, .mst_cmd_i,
        .mst_be_n_i, .mst_wdata_i, .mst_busy_o, .mst_rdata_o, .mst_rvalid_o, .tgt_addr_o, .tgt_cmd_o,
        .tgt_rdata_i, .wr_valid_o, .wr_data_o, .wr_ready_i, .tgt_stall_o);
    pci_far_agent p (.ref_clk_i, .dev_ad_i(ad_o), .dev_ad_oe_i(ad_oe_o), .dev_cbe_n_i(cbe_n_o),
        .dev_cbe_oe_i(cbe_oe_o), .dev_clkrun_n_i(clkrun_n_o), .dev_clkrun_oe_i(clkrun_oe_o),
        .wire_ad_o(ad_i), .wire_cbe_n_o(cbe_n_i), .wire_clkrun_n_o(clkrun_n_i));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] exp_addr(input logic [31:0] a);
        return {a[31:2], 2'h0};
    endfunction
    // read word: enabled lanes take new bytes, others keep the old word
    function automatic logic [31:0] exp_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be_n);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (!be_n[i]) r[i*8 +: 8] = n[i*8 +: 8];
        end
        return r;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wait_sig(ref logic s, input logic v);
        for (int i = 0; i < 60 && s !== v; i++) tick(1);
        if (s !== v) begin
            n_errors++;
            $display("BAD %0t wait ran out", $time);
            finish_test();
        end
    endtask
    task automatic pulse_done(input logic l);
        phase_done_i = 1'b1;
        last_i = l;
        tick(1);
        phase_done_i = 1'b0;
        last_i = 1'b0;
    endtask
    // one initiator transfer of a single data phase
    task automatic mst_xfer(input logic wr, input logic [31:0] a);
        logic [31:0] d;
        d = $urandom;
        mst_write_i = wr;
        mst_addr_i = a;
        mst_cmd_i = 4'($urandom);
        mst_be_n_i = 4'($urandom);
        mst_wdata_i = d;
        mst_req_i = 1'b1;
        wait_sig(mst_busy_o, 1'b1);
        mst_req_i = 1'b0;
        check(ad_oe_o, 1'b1);
        check(ad_o, exp_addr(a));
        check({cbe_oe_o, cbe_n_o}, {1'b1, mst_cmd_i});
        tick(1);
        check(cbe_n_o, mst_be_n_i);
        check({ad_oe_o, wr ? ad_o : 32'h0}, {wr, wr ? d : 32'h0});
        if (!wr) p.set_bus(d, 4'h0);
        pulse_done(1'b1);
        if (!wr) wait_sig(mst_rvalid_o, 1'b1);
        if (!wr) rd_exp = exp_merge(rd_exp, d, mst_be_n_i);
        if (!wr) check(mst_rdata_o, rd_exp);
        wait_sig(cbe_oe_o, 1'b0);
        check(ad_oe_o, 1'b0);
        p.release_bus();
        wait_sig(mst_busy_o, 1'b0);
    endtask
    task automatic tgt_addr_phase(input logic rd, input logic [31:0] a, input logic [3:0] c);
        tgt_read_i = rd;
        p.set_bus(a, c);
        tgt_start_i = 1'b1;
        tick(1);
        tgt_start_i = 1'b0;
        check(ad_oe_o, 1'b0);
        tick(4);
        check({tgt_cmd_o, tgt_addr_o}, {c, a});
        check(cbe_oe_o, 1'b0);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] d;
        logic [3:0] be;
        void'($urandom(66));
        {pci_bus_reset_in_n_i, pos_i, tgt_start_i, tgt_read_i, phase_done_i, last_i} = 6'h20;
        {stop_req_i, mst_req_i, mst_write_i, wr_ready_i} = 4'h0;
        {mst_addr_i, mst_wdata_i, tgt_rdata_i, mst_cmd_i, mst_be_n_i} = 104'h0;
        repeat (6) @(posedge ref_clk_i);
        #1;
        check({ad_oe_o, cbe_oe_o}, 2'h0);
        rst_i = 1'b0;
        tick(1);
        check({ad_oe_o, cbe_oe_o}, 2'h0);
        tick(2);
        check({clkrun_oe_o, clkrun_n_o}, 2'h3);
        mst_xfer(1'b1, 32'h89AB_CDE7);
        mst_xfer(1'b0, 32'hFFFF_FFFF);
        for (int i = 0; i < 6; i++) mst_xfer(i[0], $urandom);
        // target writes fill the queue while the far side stalls
        tgt_addr_phase(1'b0, $urandom, 4'($urandom));
        for (int i = 0; i < DEPTH; i++) begin
            d = $urandom;
            be = (i == 0) ? 4'hF : 4'($urandom);
            p.set_bus(d, be);
            exp_q.push_back({be, d});
            tick(1);
            pulse_done(i == DEPTH - 1);
            tick(3);
            if (i == DEPTH - 2) check(tgt_stall_o, 1'b0);
        end
        check(tgt_stall_o, 1'b1);
        p.release_bus();
        wr_ready_i = 1'b1;
        while (exp_q.size() > 0) begin
            wait_sig(wr_valid_o, 1'b1);
            check(wr_data_o, exp_q.pop_front());
            tick(1);
        end
        check({wr_valid_o, tgt_stall_o}, 2'h0);
        // target read supplies data, command lines stay released
        tgt_rdata_i = $urandom;
        tgt_addr_phase(1'b1, $urandom, 4'($urandom));
        wait_sig(ad_oe_o, 1'b1);
        check({cbe_oe_o, ad_o}, {1'b0, tgt_rdata_i});
        pulse_done(1'b1);
        wait_sig(ad_oe_o, 1'b0);
        p.release_bus();
        // bus reset in mid-transfer, then suspend
        mst_addr_i = $urandom;
        mst_req_i = 1'b1;
        wait_sig(mst_busy_o, 1'b1);
        mst_req_i = 1'b0;
        pci_bus_reset_in_n_i = 1'b0;
        tick(4);
        check({ad_oe_o, cbe_oe_o}, 2'h0);
        pci_bus_reset_in_n_i = 1'b1;
        tick(1);
        check({ad_oe_o, cbe_oe_o}, 2'h0);
        pos_i = 1'b1;
        tick(4);
        mst_req_i = 1'b1;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            check({ad_oe_o, cbe_oe_o}, 2'h0);
        end
        mst_req_i = 1'b0;
        rst_i = 1'b1;
        tick(2);
        check({ad_oe_o, cbe_oe_o}, 2'h0);
        rst_i = 1'b0;
        pos_i = 1'b0;
        tick(4);
        // clock-run: held line blocks the stop, assertion restarts
        stop_req_i = 1'b1;
        p.hold_clock(1'b1);
        for (int i = 0; i < 12; i++) begin
            tick(1);
            check(clk_stop_o, 1'b0);
        end
        p.hold_clock(1'b0);
        wait_sig(clk_stop_o, 1'b1);
        check(clkrun_oe_o, 1'b0);
        p.hold_clock(1'b1);
        wait_sig(clk_stop_o, 1'b0);
        stop_req_i = 1'b0;
        p.hold_clock(1'b0);
        tick(6);
        check({clk_stop_o, clkrun_oe_o, clkrun_n_o}, 3'h3);
        finish_test();
    end
endmodule // testbench
`default_nettype wire
